// [rtl/brc_pkg.sv]
// package: encodings, field positions and state carrier for the branch and copy executor
// Operation
// - unconditional branch loads effective address into program address register, floating mode irrelevant
// - unconditional branch also clears floating mode flag
// - true conditional branch loads self-relative target, no indirection or indexing
// - false conditional branch on a non-index condition is a no-operation; execution continues sequentially
// - branch_acc_negative true exactly when accumulator bit 0 is one
// - accumulator-zero branch true only when accumulator is all zero
// - branch_ext_negative true exactly when extended accumulator bit 0 is one
// - branch_if_no_overflow true only when overflow is zero; overflow unchanged
// - branch_if_no_carry true only when carry is zero; carry unchanged
// - branch_index_increment adds one to index 1, branches if nonzero
// - index_incr_no_overflow does nothing if overflow set; else increments, overflow unchanged
// - index_incr_no_carry does nothing if carry set; else increments, carry unchanged
// - register copy recognised by opcode 7, independent of floating mode
// - logic_function selects and, or, xor, add; only add updates indicators
// - carry_in_select adds current carry into result low bit
// - increment_select adds one; with both set exactly one is added
// - clear_destination uses zero as destination operand
// - result_target picks which general register receives the result
// - invert_source uses complemented source, stored source unchanged
// - source_select zero supplies an all-zero operand
// - register addresses: zero, program, link, temp, index1, index2, ext acc, acc
// - program address read by copy is already incremented value
package brc_pkg;
  localparam int unsigned BRC_W = 16;

  // opcode field, instruction bits 0-3 counted from the msb
  localparam logic [3:0] BRC_OPC_BRANCH = 4'h4;
  localparam logic [3:0] BRC_OPC_COND = 4'h6;
  localparam logic [3:0] BRC_OPC_COPY = 4'h7;

  // field positions; bit k counted from the msb is vector bit 15-k
  localparam int unsigned BRC_OPC_LSB = 12;
  localparam int unsigned BRC_FN_LSB = 10;
  localparam int unsigned BRC_AC_BIT = 9;
  localparam int unsigned BRC_AI_BIT = 8;
  localparam int unsigned BRC_CD_BIT = 7;
  localparam int unsigned BRC_DR_LSB = 4;
  localparam int unsigned BRC_IS_BIT = 3;
  localparam int unsigned BRC_SR_LSB = 0;
  localparam int unsigned BRC_CND_LSB = 9;
  localparam int unsigned BRC_DISP_W = 9;

  // conditional branch selector, bits 4-6 counted from the msb
  localparam logic [2:0] BRC_C_NO_OVF = 3'h0;
  localparam logic [2:0] BRC_C_NO_CARRY = 3'h1;
  localparam logic [2:0] BRC_C_ACC_ZERO = 3'h2;
  localparam logic [2:0] BRC_C_IDX_INC = 3'h3;
  localparam logic [2:0] BRC_C_ACC_NEG = 3'h4;
  localparam logic [2:0] BRC_C_IDX_NO_OVF = 3'h5;
  localparam logic [2:0] BRC_C_EXT_NEG = 3'h6;
  localparam logic [2:0] BRC_C_IDX_NO_CARRY = 3'h7;

  // logic_function codes
  localparam logic [1:0] BRC_FN_AND = 2'h0;
  localparam logic [1:0] BRC_FN_OR = 2'h1;
  localparam logic [1:0] BRC_FN_XOR = 2'h2;
  localparam logic [1:0] BRC_FN_ADD = 2'h3;

  // general register addresses
  localparam logic [2:0] BRC_R_ZERO = 3'h0;
  localparam logic [2:0] BRC_R_PROG = 3'h1;
  localparam logic [2:0] BRC_R_LINK = 3'h2;
  localparam logic [2:0] BRC_R_TEMP = 3'h3;
  localparam logic [2:0] BRC_R_IDX1 = 3'h4;
  localparam logic [2:0] BRC_R_IDX2 = 3'h5;
  localparam logic [2:0] BRC_R_EXT = 3'h6;
  localparam logic [2:0] BRC_R_ACC = 3'h7;

  // reset values
  localparam logic [15:0] BRC_REG_RST = 16'h0000;
  localparam logic BRC_FLAG_RST = 1'b0;

  typedef struct packed {
    logic [15:0] acc;
    logic [15:0] ext;
    logic [15:0] idx2;
    logic [15:0] idx1;
    logic [15:0] temp;
    logic [15:0] link;
    logic [15:0] prog;
    logic overflow;
    logic carry;
    logic floating_mode_flag;
  } brc_state_t;

  typedef struct packed {
    logic valid;
    logic [15:0] word;
    logic [15:0] eff_addr;
  } brc_exec_t;

  typedef struct packed {
    logic wr_en;
    logic [2:0] sel;
    logic [15:0] data;
    logic flags_en;
    logic overflow;
    logic carry;
    logic floating_mode_flag;
  } brc_load_t;
endpackage

// [rtl/brc_exec.sv]
// branch, conditional branch and register copy execution with the general register file
`timescale 1ns/1ns
module brc_exec
  import brc_pkg::*;
#(
  parameter int unsigned WIDTH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire brc_exec_t exec_in,
  input wire logic fetch_step,
  input wire brc_load_t load_in,
  output brc_state_t state_out,
  output logic branch_taken,
  output logic exec_done,
  output logic unknown_op
);

  if (WIDTH != BRC_W) begin : g_chk
    $error("brc_exec supports only a 16-bit word");
  end

  logic [15:0] regs_r [0:7];
  logic ovf_r;
  logic carry_r;
  logic fm_r;
  logic taken_r;
  logic done_r;
  logic unk_r;

  // field decode
  wire [15:0] iw = exec_in.word;
  wire [3:0] opc = iw[BRC_OPC_LSB +: 4];
  wire is_branch = exec_in.valid && (opc == BRC_OPC_BRANCH);
  wire is_cond = exec_in.valid && (opc == BRC_OPC_COND);
  wire is_copy = exec_in.valid && (opc == BRC_OPC_COPY);
  wire is_unknown = exec_in.valid && !is_branch && !is_cond && !is_copy;
  wire [2:0] cnd = iw[BRC_CND_LSB +: 3];
  wire [1:0] fn = iw[BRC_FN_LSB +: 2];
  wire ac = iw[BRC_AC_BIT];
  wire ai = iw[BRC_AI_BIT];
  wire cd = iw[BRC_CD_BIT];
  wire [2:0] dr = iw[BRC_DR_LSB +: 3];
  wire inv = iw[BRC_IS_BIT];
  wire [2:0] sr = iw[BRC_SR_LSB +: 3];

  // conditional branch: target relative to this instruction, P already points past it
  wire [15:0] self_addr = regs_r[BRC_R_PROG] - 16'h0001;
  wire [15:0] disp_ext = {{(16 - BRC_DISP_W){iw[BRC_DISP_W - 1]}}, iw[BRC_DISP_W - 1:0]};
  wire [15:0] cond_target = self_addr + disp_ext;
  wire [15:0] idx_inc = regs_r[BRC_R_IDX1] + 16'h0001;
  wire idx_nz = (idx_inc != 16'h0000);

  wire c_acc_neg = regs_r[BRC_R_ACC][15];
  wire c_acc_zero = (regs_r[BRC_R_ACC] == 16'h0000);
  wire c_ext_neg = regs_r[BRC_R_EXT][15];
  wire c_no_ovf = !ovf_r;
  wire c_no_carry = !carry_r;
  // index forms only touch index 1 when their gating indicator is clear
  wire idx_go = (cnd == BRC_C_IDX_INC) ||
                ((cnd == BRC_C_IDX_NO_OVF) && !ovf_r) ||
                ((cnd == BRC_C_IDX_NO_CARRY) && !carry_r);
  wire idx_write = is_cond && idx_go;

  logic cond_true;
  always_comb begin
    unique case (cnd)
      BRC_C_NO_OVF: cond_true = c_no_ovf;
      BRC_C_NO_CARRY: cond_true = c_no_carry;
      BRC_C_ACC_ZERO: cond_true = c_acc_zero;
      BRC_C_ACC_NEG: cond_true = c_acc_neg;
      BRC_C_EXT_NEG: cond_true = c_ext_neg;
      BRC_C_IDX_INC: cond_true = idx_nz;
      BRC_C_IDX_NO_OVF: cond_true = !ovf_r && idx_nz;
      BRC_C_IDX_NO_CARRY: cond_true = !carry_r && idx_nz;
    endcase
  end
  wire cond_taken = is_cond && cond_true;

  // copy datapath; register 0 reads zero, register 1 reads the incremented P
  wire [15:0] src_raw = (sr == BRC_R_ZERO) ? 16'h0000 : regs_r[sr];
  wire [15:0] dst_op = cd ? 16'h0000 : regs_r[dr];
  wire [15:0] src_op = inv ? ~src_raw : src_raw;
  // both select bits set adds exactly one, whatever carry holds
  wire add_in = ai ? 1'b1 : (ac ? carry_r : 1'b0);
  wire [16:0] sum = {1'b0, dst_op} + {1'b0, src_op} + {16'h0000, add_in};

  logic [15:0] logic_res;
  always_comb begin
    unique case (fn)
      BRC_FN_AND: logic_res = dst_op & src_op;
      BRC_FN_OR: logic_res = dst_op | src_op;
      BRC_FN_XOR: logic_res = dst_op ^ src_op;
      BRC_FN_ADD: logic_res = dst_op;
    endcase
  end
  wire is_add = (fn == BRC_FN_ADD);
  wire [15:0] logic_fin = logic_res + {15'h0000, add_in};
  wire [15:0] copy_res = is_add ? sum[15:0] : logic_fin;
  // signed overflow from operand signs against the final result
  wire add_ovf = (dst_op[15] == src_op[15]) && (sum[15] != dst_op[15]);
  wire copy_flags = is_copy && is_add;

  // P: executed writes win, the fetch step only advances when nothing executes
  logic [15:0] prog_nxt;
  always_comb begin
    prog_nxt = regs_r[BRC_R_PROG];
    if (is_branch) begin
      prog_nxt = exec_in.eff_addr;
    end else if (cond_taken) begin
      prog_nxt = cond_target;
    end else if (is_copy && dr == BRC_R_PROG) begin
      prog_nxt = copy_res;
    end else if (!exec_in.valid && load_in.wr_en && load_in.sel == BRC_R_PROG) begin
      prog_nxt = load_in.data;
    end else if (!exec_in.valid && fetch_step) begin
      prog_nxt = regs_r[BRC_R_PROG] + 16'h0001;
    end
  end

  assign regs_r[0] = BRC_REG_RST;

  // one writer process per general register 2..7
  for (genvar g = 2; g < 8; g++) begin : g_reg
    wire copy_hit = is_copy && (dr == 3'(g));
    wire idx_hit = idx_write && (g == BRC_R_IDX1);
    wire load_hit = !exec_in.valid && load_in.wr_en && (load_in.sel == 3'(g));
    wire [15:0] reg_nxt = copy_hit ? copy_res : (idx_hit ? idx_inc : load_in.data);
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        regs_r[g] <= BRC_REG_RST;
      end else if (copy_hit || idx_hit || load_hit) begin
        regs_r[g] <= reg_nxt;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      regs_r[1] <= BRC_REG_RST;
    end else begin
      regs_r[1] <= prog_nxt;
    end
  end

  // indicators: the add form of copy or an idle core flag load changes them; branches keep overflow and carry; unconditional branch clears floating mode
  wire flags_load = !exec_in.valid && load_in.flags_en;
  wire ovf_nxt = copy_flags ? add_ovf : (flags_load ? load_in.overflow : ovf_r);
  wire carry_nxt = copy_flags ? sum[16] : (flags_load ? load_in.carry : carry_r);
  wire fm_nxt = is_branch ? 1'b0 : (flags_load ? load_in.floating_mode_flag : fm_r);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ovf_r <= BRC_FLAG_RST;
      carry_r <= BRC_FLAG_RST;
      fm_r <= BRC_FLAG_RST;
    end else begin
      ovf_r <= ovf_nxt;
      carry_r <= carry_nxt;
      fm_r <= fm_nxt;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      taken_r <= 1'b0;
      done_r <= 1'b0;
      unk_r <= 1'b0;
    end else begin
      taken_r <= is_branch || cond_taken;
      done_r <= exec_in.valid;
      unk_r <= is_unknown;
    end
  end

  assign state_out.acc = regs_r[BRC_R_ACC];
  assign state_out.ext = regs_r[BRC_R_EXT];
  assign state_out.idx2 = regs_r[BRC_R_IDX2];
  assign state_out.idx1 = regs_r[BRC_R_IDX1];
  assign state_out.temp = regs_r[BRC_R_TEMP];
  assign state_out.link = regs_r[BRC_R_LINK];
  assign state_out.prog = regs_r[BRC_R_PROG];
  assign state_out.overflow = ovf_r;
  assign state_out.carry = carry_r;
  assign state_out.floating_mode_flag = fm_r;
  assign branch_taken = taken_r;
  assign exec_done = done_r;
  assign unknown_op = unk_r;

  // checks
  branch_target_a: assert property (@(posedge clock) disable iff (!rst_n)
    is_branch |=> (regs_r[BRC_R_PROG] == $past(exec_in.eff_addr)) && branch_taken)
    else $error("branch did not load effective address");

  branch_fm_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    is_branch |=> !fm_r)
    else $error("branch left floating mode set");

  cond_taken_a: assert property (@(posedge clock) disable iff (!rst_n)
    cond_taken |=> regs_r[BRC_R_PROG] == $past(regs_r[BRC_R_PROG]) - 16'h0001 + $past(disp_ext))
    else $error("taken branch target wrong");

  cond_nop_a: assert property (@(posedge clock) disable iff (!rst_n)
    (is_cond && !cond_true) |=> $stable(regs_r[BRC_R_PROG]) && !branch_taken)
    else $error("untaken branch moved program address");

  acc_neg_a: assert property (@(posedge clock) disable iff (!rst_n)
    (is_cond && cnd == BRC_C_ACC_NEG) |=> branch_taken == $past(regs_r[BRC_R_ACC][15]))
    else $error("accumulator negative test wrong");

  acc_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
    (is_cond && cnd == BRC_C_ACC_ZERO) |=> branch_taken == ($past(regs_r[BRC_R_ACC]) == 16'h0000))
    else $error("accumulator zero test wrong");

  ext_neg_a: assert property (@(posedge clock) disable iff (!rst_n)
    (is_cond && cnd == BRC_C_EXT_NEG) |=> branch_taken == $past(regs_r[BRC_R_EXT][15]))
    else $error("extended accumulator negative test wrong");

  cond_flags_a: assert property (@(posedge clock) disable iff (!rst_n)
    is_cond |=> $stable(ovf_r) && $stable(carry_r))
    else $error("conditional branch changed an indicator");

  index_inc_a: assert property (@(posedge clock) disable iff (!rst_n)
    idx_write |=> (regs_r[BRC_R_IDX1] == $past(regs_r[BRC_R_IDX1]) + 16'h0001)
      && (branch_taken == (regs_r[BRC_R_IDX1] != 16'h0000)))
    else $error("index increment branch wrong");

  index_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
    (is_cond && cnd == BRC_C_IDX_NO_OVF && ovf_r) |=> $stable(regs_r[BRC_R_IDX1]) && !branch_taken)
    else $error("gated index increment acted with overflow set");

  logic_flags_a: assert property (@(posedge clock) disable iff (!rst_n)
    (is_copy && !is_add) |=> $stable(ovf_r) && $stable(carry_r))
    else $error("logical copy changed an indicator");

  both_incr_a: assert property (@(posedge clock) disable iff (!rst_n)
    (is_copy && ac && ai && fn == BRC_FN_OR && cd && !inv && sr == BRC_R_ZERO && dr == BRC_R_ACC)
      |=> regs_r[BRC_R_ACC] == 16'h0001)
    else $error("increment with carry select added wrong amount");

  zero_source_a: assert property (@(posedge clock) disable iff (!rst_n)
    (is_copy && fn == BRC_FN_OR && cd && !ac && !ai && !inv && sr == BRC_R_ZERO && dr == BRC_R_ACC)
      |=> regs_r[BRC_R_ACC] == 16'h0000)
    else $error("zero source not all zero");

  no_ovf_a: assert property (@(posedge clock) disable iff (!rst_n)
    (is_cond && cnd == BRC_C_NO_OVF) |=> branch_taken == !$past(ovf_r))
    else $error("no overflow branch test wrong");

  no_carry_a: assert property (@(posedge clock) disable iff (!rst_n)
    (is_cond && cnd == BRC_C_NO_CARRY) |=> branch_taken == !$past(carry_r))
    else $error("no carry branch test wrong");

  carry_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
    (is_cond && cnd == BRC_C_IDX_NO_CARRY && carry_r) |=> $stable(regs_r[BRC_R_IDX1]) && !branch_taken)
    else $error("gated index increment acted with carry set");

  carry_in_a: assert property (@(posedge clock) disable iff (!rst_n)
    (is_copy && ac && !ai && !is_add && dr == BRC_R_ACC)
      |=> regs_r[BRC_R_ACC] == $past(logic_res) + {15'h0000, $past(carry_r)})
    else $error("carry not added into result");

  incr_only_a: assert property (@(posedge clock) disable iff (!rst_n)
    (is_copy && ai && !is_add && dr == BRC_R_ACC)
      |=> regs_r[BRC_R_ACC] == $past(logic_res) + 16'h0001)
    else $error("increment did not add exactly one");

  clear_dest_a: assert property (@(posedge clock) disable iff (!rst_n)
    (is_copy && cd && fn == BRC_FN_OR && !ac && !ai && dr == BRC_R_ACC)
      |=> regs_r[BRC_R_ACC] == $past(src_op))
    else $error("cleared destination not used as zero");

  source_kept_a: assert property (@(posedge clock) disable iff (!rst_n)
    (is_copy && sr == BRC_R_TEMP && dr != BRC_R_TEMP) |=> $stable(regs_r[BRC_R_TEMP]))
    else $error("source register changed");

  link_kept_a: assert property (@(posedge clock) disable iff (!rst_n)
    (is_copy && dr != BRC_R_LINK) |=> $stable(regs_r[BRC_R_LINK]))
    else $error("copy wrote a register it does not target");

  zero_dest_a: assert property (@(posedge clock) disable iff (!rst_n)
    (is_copy && dr == BRC_R_ZERO)
      |=> $stable(regs_r[BRC_R_ACC]) && $stable(regs_r[BRC_R_TEMP]) && $stable(regs_r[BRC_R_PROG]))
    else $error("copy to zero register changed state");

  prog_plus_a: assert property (@(posedge clock) disable iff (!rst_n)
    (is_copy && sr == BRC_R_PROG && cd && !inv && fn == BRC_FN_OR && ai && !ac && dr == BRC_R_LINK)
      |=> regs_r[BRC_R_LINK] == $past(regs_r[BRC_R_PROG]) + 16'h0001)
    else $error("program address operand not the next address");

  negate_order_a: assert property (@(posedge clock) disable iff (!rst_n)
    (is_copy && cd && inv && is_add && ai && !ac && dr == BRC_R_ACC)
      |=> regs_r[BRC_R_ACC] == 16'h0000 - $past(src_raw))
    else $error("negate sequence gave wrong result");

  clear_add_a: assert property (@(posedge clock) disable iff (!rst_n)
    (is_copy && is_add && cd && !ac && !ai) |=> !ovf_r && !carry_r)
    else $error("add into cleared destination set an indicator");

  unknown_quiet_a: assert property (@(posedge clock) disable iff (!rst_n)
    is_unknown
      |=> unknown_op && $stable(regs_r[BRC_R_PROG]) && $stable(ovf_r) && $stable(carry_r) && $stable(fm_r))
    else $error("unknown opcode changed state");

  done_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
    exec_in.valid |=> exec_done)
    else $error("done pulse missing");

  idle_quiet_a: assert property (@(posedge clock) disable iff (!rst_n)
    !exec_in.valid |=> !exec_done && !branch_taken && !unknown_op)
    else $error("pulse without an instruction");

  taken_only_a: assert property (@(posedge clock) disable iff (!rst_n)
    (exec_in.valid && !is_branch && !cond_taken) |=> !branch_taken)
    else $error("taken pulse without a branch");

  prog_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    (exec_in.valid && !is_branch && !cond_taken && !(is_copy && dr == BRC_R_PROG))
      |=> $stable(regs_r[BRC_R_PROG]))
    else $error("program address moved without a branch");

  mode_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
    (exec_in.valid && !is_branch) |=> $stable(fm_r))
    else $error("floating mode changed by a non-branch");

  idx_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    (exec_in.valid && !idx_write && !(is_copy && dr == BRC_R_IDX1))
      |=> $stable(regs_r[BRC_R_IDX1]))
    else $error("index one changed without an increment");

  jump_flags_a: assert property (@(posedge clock) disable iff (!rst_n)
    is_branch |=> $stable(ovf_r) && $stable(carry_r))
    else $error("branch changed an indicator");

  ext_target_a: assert property (@(posedge clock) disable iff (!rst_n)
    (is_copy && dr == BRC_R_EXT && cd && fn == BRC_FN_OR && !ac && !ai && !inv)
      |=> regs_r[BRC_R_EXT] == $past(src_raw))
    else $error("copy to extended accumulator wrong");

  idx2_target_a: assert property (@(posedge clock) disable iff (!rst_n)
    (is_copy && dr == BRC_R_IDX2 && cd && fn == BRC_FN_OR && !ac && !ai && !inv)
      |=> regs_r[BRC_R_IDX2] == $past(src_raw))
    else $error("copy to index two wrong");

  fetch_step_a: assert property (@(posedge clock) disable iff (!rst_n)
    (!exec_in.valid && fetch_step && !(load_in.wr_en && load_in.sel == BRC_R_PROG))
      |=> regs_r[BRC_R_PROG] == $past(regs_r[BRC_R_PROG]) + 16'h0001)
    else $error("fetch step did not advance the program address");

  cover_branch_c: cover property (@(posedge clock) disable iff (!rst_n) is_branch);
  cover_cond_c: cover property (@(posedge clock) disable iff (!rst_n) cond_taken ##1 (is_cond && !cond_true));
  cover_add_c: cover property (@(posedge clock) disable iff (!rst_n) copy_flags && sum[16]);
  cover_idx_c: cover property (@(posedge clock) disable iff (!rst_n) idx_write && !idx_nz);
  cover_prog_src_c: cover property (@(posedge clock) disable iff (!rst_n) is_copy && sr == BRC_R_PROG);

endmodule

// [tb/tb_top.sv]
// self-checking bench for the branch and register copy executor
`timescale 1ns/1ns
module tb_top;
  import brc_pkg::*;
  typedef struct packed {logic [15:0] w, d, s; logic ov, cy; logic [15:0] r; logic eov, ecy;} brc_cp_row_t;
  typedef struct packed {logic [2:0] c; logic ov, cy; logic [15:0] a, e, x; logic tk; logic [15:0] ex;} brc_br_row_t;
  logic clock;
  logic rst_n;
  logic fetch_step;
  brc_exec_t exec_in;
  brc_load_t load_in;
  brc_state_t state_out;
  logic branch_taken;
  logic exec_done;
  logic unknown_op;
  int n_errors = 0;
  int total_checks = 0;
  // copy rows: word, dest, source, ov/cy in, result, ov/cy out; dest is acc, source temp except rows whose word selects zero or acc
  brc_cp_row_t cp_rows [16] = '{
    '{16'h7073, 16'h00f0, 16'h0f33, 1'h1, 1'h1, 16'h0030, 1'h1, 1'h1},
    '{16'h7473, 16'h00f0, 16'h0f33, 1'h0, 1'h0, 16'h0ff3, 1'h0, 1'h0},
    '{16'h7873, 16'h00f0, 16'h0f33, 1'h0, 1'h1, 16'h0fc3, 1'h0, 1'h1},
    '{16'h7c73, 16'h00f0, 16'h0f33, 1'h1, 1'h1, 16'h1023, 1'h0, 1'h0},
    '{16'h7673, 16'h00f0, 16'h0f33, 1'h0, 1'h1, 16'h0ff4, 1'h0, 1'h1},
    '{16'h7773, 16'h00f0, 16'h0f33, 1'h0, 1'h1, 16'h0ff4, 1'h0, 1'h1},
    '{16'h7973, 16'h00f0, 16'h0f33, 1'h0, 1'h0, 16'h0fc4, 1'h0, 1'h0},
    '{16'h74f3, 16'h00f0, 16'h0f33, 1'h0, 1'h0, 16'h0f33, 1'h0, 1'h0},
    '{16'h747b, 16'h00f0, 16'h0f33, 1'h0, 1'h0, 16'hf0fc, 1'h0, 1'h0},
    '{16'h7470, 16'h00f0, 16'h0f33, 1'h0, 1'h0, 16'h00f0, 1'h0, 1'h0},
    '{16'h7c73, 16'h7fff, 16'h0001, 1'h0, 1'h0, 16'h8000, 1'h1, 1'h0},
    '{16'h7c73, 16'hffff, 16'h0001, 1'h0, 1'h0, 16'h0000, 1'h0, 1'h1},
    '{16'h7e73, 16'h0001, 16'h0002, 1'h0, 1'h1, 16'h0004, 1'h0, 1'h0},
    '{16'h7dff, 16'h0005, 16'h0f33, 1'h0, 1'h0, 16'hfffb, 1'h0, 1'h0},
    '{16'h7c78, 16'h0005, 16'h0f33, 1'h0, 1'h0, 16'h0004, 1'h0, 1'h1},
    '{16'h74f0, 16'h1234, 16'h0f33, 1'h1, 1'h1, 16'h0000, 1'h1, 1'h1}};
  // branch rows: condition, ov, cy, acc, ext, index 1, taken, index 1 after
  brc_br_row_t br_rows [16] = '{
    '{BRC_C_NO_OVF, 1'h0, 1'h0, 16'h0001, 16'h0001, 16'h0005, 1'h1, 16'h0005},
    '{BRC_C_NO_OVF, 1'h1, 1'h0, 16'h0001, 16'h0001, 16'h0005, 1'h0, 16'h0005},
    '{BRC_C_NO_CARRY, 1'h0, 1'h0, 16'h0001, 16'h0001, 16'h0005, 1'h1, 16'h0005},
    '{BRC_C_NO_CARRY, 1'h0, 1'h1, 16'h0001, 16'h0001, 16'h0005, 1'h0, 16'h0005},
    '{BRC_C_ACC_ZERO, 1'h0, 1'h0, 16'h0000, 16'h0001, 16'h0005, 1'h1, 16'h0005},
    '{BRC_C_ACC_ZERO, 1'h0, 1'h0, 16'h0001, 16'h0001, 16'h0005, 1'h0, 16'h0005},
    '{BRC_C_ACC_NEG, 1'h0, 1'h0, 16'h8000, 16'h0001, 16'h0005, 1'h1, 16'h0005},
    '{BRC_C_ACC_NEG, 1'h0, 1'h0, 16'h7fff, 16'h0001, 16'h0005, 1'h0, 16'h0005},
    '{BRC_C_EXT_NEG, 1'h0, 1'h0, 16'h0001, 16'h8000, 16'h0005, 1'h1, 16'h0005},
    '{BRC_C_EXT_NEG, 1'h0, 1'h0, 16'h0001, 16'h7fff, 16'h0005, 1'h0, 16'h0005},
    '{BRC_C_IDX_INC, 1'h0, 1'h0, 16'h0001, 16'h0001, 16'hffff, 1'h0, 16'h0000},
    '{BRC_C_IDX_INC, 1'h0, 1'h0, 16'h0001, 16'h0001, 16'h0005, 1'h1, 16'h0006},
    '{BRC_C_IDX_NO_OVF, 1'h1, 1'h0, 16'h0001, 16'h0001, 16'h0005, 1'h0, 16'h0005},
    '{BRC_C_IDX_NO_OVF, 1'h0, 1'h1, 16'h0001, 16'h0001, 16'h0005, 1'h1, 16'h0006},
    '{BRC_C_IDX_NO_CARRY, 1'h0, 1'h1, 16'h0001, 16'h0001, 16'h0005, 1'h0, 16'h0005},
    '{BRC_C_IDX_NO_CARRY, 1'h1, 1'h0, 16'h0001, 16'h0001, 16'h0005, 1'h1, 16'h0006}};

  brc_exec #(.WIDTH(16)) u_brc_exec (.clock(clock), .rst_n(rst_n), .exec_in(exec_in), .fetch_step(fetch_step),
    .load_in(load_in), .state_out(state_out), .branch_taken(branch_taken), .exec_done(exec_done),
    .unknown_op(unknown_op));

  initial begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp, input string m);
    chk({15'h0000, got}, {15'h0000, exp}, m);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // core-side loads take two edges each; slow but keeps one assignment per edge
  task automatic ld(input logic [2:0] s, input logic [15:0] d);
    @(posedge clock) load_in <= '{1'h1, s, d, 1'h0, 1'h0, 1'h0, 1'h0};
    @(posedge clock) load_in <= '0;
  endtask

  task automatic pre(input logic ov, cy, fm, input logic [15:0] a, e, x, t, p);
    @(posedge clock) load_in <= '{1'h0, 3'h0, 16'h0000, 1'h1, ov, cy, fm};
    @(posedge clock) load_in <= '0;
    ld(BRC_R_ACC, a);
    ld(BRC_R_EXT, e);
    ld(BRC_R_IDX1, x);
    ld(BRC_R_TEMP, t);
    ld(BRC_R_PROG, p);
  endtask

  // one instruction; outputs read 1 ns after the taking edge, while pulses still stand
  task automatic run(input logic [15:0] w, input logic [15:0] ea);
    @(posedge clock) exec_in <= '{1'h1, w, ea};
    @(posedge clock) exec_in <= '0;
    #1;
  endtask

  initial begin
    repeat (50000) @(posedge clock);
    n_errors++;
    report_and_stop;
  end

  initial begin
    rst_n = 1'h0;
    fetch_step = 1'h0;
    exec_in = '0;
    load_in = '0;
    repeat (20) @(posedge clock);
    chkb(state_out === '0 && branch_taken === 1'h0 && exec_done === 1'h0, 1'h1, "reset state");
    @(posedge clock) rst_n <= 1'h1;
    foreach (cp_rows[i]) begin
      pre(cp_rows[i].ov, cp_rows[i].cy, i[0], cp_rows[i].d, 16'h0001, 16'h0005, cp_rows[i].s, 16'h0200);
      run(cp_rows[i].w, 16'h0000);
      chk(state_out.acc, cp_rows[i].r, "copy result");
      chkb(state_out.overflow, cp_rows[i].eov, "copy overflow");
      chkb(state_out.carry, cp_rows[i].ecy, "copy carry");
      chk(state_out.temp, cp_rows[i].s, "source kept");
      chkb(state_out.floating_mode_flag, i[0], "mode kept");
      chkb(exec_done, 1'h1, "done pulse");
      chkb(unknown_op, 1'h0, "no unknown flag");
    end
    $display("copy table finished");
    foreach (br_rows[i]) begin
      pre(br_rows[i].ov, br_rows[i].cy, 1'h1, br_rows[i].a, br_rows[i].e, br_rows[i].x, 16'h0000, 16'h0200);
      run({BRC_OPC_COND, br_rows[i].c, 9'h1f0}, 16'h0000);
      // target is the instruction address 0x01ff minus 16
      chk(state_out.prog, br_rows[i].tk ? 16'h01ef : 16'h0200, "branch address");
      chkb(branch_taken, br_rows[i].tk, "taken pulse");
      chk(state_out.idx1, br_rows[i].ex, "index one");
      chkb(state_out.overflow, br_rows[i].ov, "overflow kept");
      chkb(state_out.carry, br_rows[i].cy, "carry kept");
    end
    $display("branch table finished");
    pre(1'h1, 1'h1, 1'h1, 16'h0001, 16'h0001, 16'h0005, 16'h0000, 16'h0200);
    run(16'h4000, 16'h1234);
    chk(state_out.prog, 16'h1234, "jump address");
    chkb(state_out.floating_mode_flag, 1'h0, "mode cleared");
    chkb(branch_taken, 1'h1, "jump pulse");
    $display("unconditional branch finished");
    pre(1'h0, 1'h0, 1'h0, 16'h0077, 16'h0001, 16'h0005, 16'h0033, 16'h0300);
    run(16'h75a1, 16'h0000);
    chk(state_out.link, 16'h0301, "next address plus one");
    run(16'h7503, 16'h0000);
    chk(state_out.acc, 16'h0077, "zero register write");
    chk(state_out.temp, 16'h0033, "zero register write");
    run(16'h74d7, 16'h0000);
    chk(state_out.idx2, 16'h0077, "copy to index two");
    run(16'h74e3, 16'h0000);
    chk(state_out.ext, 16'h0033, "copy to extended accumulator");
    run(16'h1234, 16'h0000);
    chkb(unknown_op, 1'h1, "unknown flag");
    chk(state_out.prog, 16'h0300, "unknown op state");
    $display("targets and unknown op finished");
    // back to back, with core loads that must lose to execution
    @(posedge clock) exec_in <= '{1'h1, 16'h7c78, 16'h0000};
    load_in <= '{1'h1, BRC_R_ACC, 16'hbeef, 1'h1, 1'h1, 1'h1, 1'h1};
    fetch_step <= 1'h1;
    @(posedge clock) exec_in <= '{1'h1, 16'h7c78, 16'h0000};
    @(posedge clock) exec_in <= '0;
    load_in <= '0;
    fetch_step <= 1'h0;
    #1;
    chk(state_out.acc, 16'h0075, "two decrements");
    chk(state_out.prog, 16'h0300, "step ignored");
    chkb(state_out.floating_mode_flag, 1'h0, "flag load ignored");
    @(posedge clock) fetch_step <= 1'h1;
    @(posedge clock) fetch_step <= 1'h0;
    #1;
    chk(state_out.prog, 16'h0301, "fetch step");
    run(16'h77f0, 16'h0000);
    chk(state_out.acc, 16'h0001, "carry and increment adds one");
    chkb(state_out.carry, 1'h1, "carry kept by or");
    run(16'h7cf3, 16'h0000);
    chk(state_out.acc, 16'h0033, "clear and add");
    chkb(state_out.overflow | state_out.carry, 1'h0, "clear and add indicators");
    $display("back to back finished");
    @(posedge clock) rst_n <= 1'h0;
    repeat (2) @(posedge clock);
    #1;
    chkb(state_out === '0, 1'h1, "second reset");
    @(posedge clock) rst_n <= 1'h1;
    run(16'h7c78, 16'h0000);
    chk(state_out.acc, 16'hffff, "first instruction after reset");
    $display("second reset finished");
    report_and_stop;
  end
endmodule
